/* File: src/hbs_host_bus_slave_port.sv */
// Host bus slave port: local-bus latch, asynchronous I/O strobes and ready.
module hbs_host_bus_slave_port
#(
  parameter int WAIT_CNT = hbs_pkg::WAIT_CYCLES
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Mode and base
  input  wire logic        local_bus_mode,
  input  wire logic [11:0] io_base,
  // Host address and qualifiers
  input  wire logic [15:1] host_addr,
  input  wire logic [3:0]  byte_lane_enables_n,
  input  wire logic        io_space_qualifier,
  input  wire logic        address_strobe_n,
  input  wire logic        cycle_start_n,
  input  wire logic        write_not_read_dir,
  // Strobes
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  // Data
  input  wire logic [31:0] host_data_in,
  output logic      [31:0] host_data_out,
  output logic      [31:0] host_data_oe_n,
  // Handshake and claim
  output logic             async_ready_out,
  output logic             local_device_claim_n,
  // User side
  output logic      [15:1] reg_addr,
  output logic      [3:0]  reg_lanes,
  output logic             reg_wr_pulse,
  output logic             reg_rd_pulse,
  output logic      [31:0] reg_wr_data,
  input  wire logic [31:0] reg_rd_data
);
  default clocking chk_clk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  if (WAIT_CNT < 1 || WAIT_CNT > 255)
    $error("WAIT_CNT out of range");

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Every host bus pin passes two flops; the first stage is read only by the second.
  localparam int SW = 15 + 4 + 6 + 32;
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_r <= {SW{1'b1}};
      s2_r <= {SW{1'b1}};
    end
    else
    begin
      s1_r <= {host_addr, byte_lane_enables_n, io_space_qualifier, address_strobe_n,
               cycle_start_n, write_not_read_dir, read_strobe_n, write_strobe_n,
               host_data_in};
      s2_r <= s1_r;
    end
  end
  logic [15:1] a_s;
  logic [3:0]  be_s;
  logic        aen_s, ads_s, cyc_s, wnr_s, rd_s, wr_s;
  logic [31:0] d_s;
  assign {a_s, be_s, aen_s, ads_s, cyc_s, wnr_s, rd_s, wr_s, d_s} = s2_r;

  // ==========================================================================
  // Local-bus address latch
  // ==========================================================================
  logic [15:1] la_r;
  logic [3:0]  lbe_r;
  logic        laen_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      la_r   <= '0;
      lbe_r  <= hbs_pkg::LANES_NONE;
      laen_r <= 1'b1;
    end
    else if (!ads_s)
    begin
      la_r   <= a_s; // RQ10
      lbe_r  <= be_s; // RQ10
      laen_r <= aen_s; // RQ10
    end
  end

  // Transparent while the strobe is low, held once it rises.
  logic [15:1] ea;
  logic [3:0]  ebe;
  logic        eaen;
  always_comb
  begin
    ea   = a_s;
    ebe  = {2'b11, be_s[1:0]}; // RQ2
    eaen = aen_s;
    if (local_bus_mode)
    begin
      ea   = ads_s ? la_r : a_s; // RQ10
      ebe  = ads_s ? lbe_r : be_s; // RQ10
      eaen = ads_s ? laen_r : aen_s; // RQ10
    end
  end

  function automatic logic lanes_legal(input logic [3:0] be);
    unique case (be) // RQ1
      hbs_pkg::LANES_DWORD, hbs_pkg::LANES_LOW_WORD, hbs_pkg::LANES_HIGH_WORD,
      4'hE, 4'hD, 4'hB, 4'h7: lanes_legal = 1'b1;
      default: lanes_legal = 1'b0;
    endcase
  endfunction

  logic hit;
  assign hit = !eaen && (ea[15:4] == io_base); // RQ3 RQ4

  // ==========================================================================
  // Claim output
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      local_device_claim_n <= 1'b1;
    else
      local_device_claim_n <= !hit; // RQ8
  end

  // ==========================================================================
  // Access sequencer
  // ==========================================================================
  hbs_pkg::hbs_state_t st_r;
  logic [7:0] wcnt_r;
  logic       rd_d_r, wr_d_r, dir_r, cyc_d_r;
  logic       rd_lead, wr_trail, cyc_first;
  assign rd_lead   = rd_d_r && !rd_s;
  assign wr_trail  = !wr_d_r && wr_s;
  assign cyc_first = cyc_d_r && !cyc_s;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_d_r  <= 1'b1;
      wr_d_r  <= 1'b1;
      cyc_d_r <= 1'b1;
      dir_r   <= 1'b0;
    end
    else
    begin
      rd_d_r  <= rd_s;
      wr_d_r  <= wr_s;
      cyc_d_r <= cyc_s;
      if (cyc_first)
        dir_r <= wnr_s; // RQ9
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r            <= hbs_pkg::HBS_IDLE;
      wcnt_r          <= '0;
      async_ready_out <= 1'b1;
    end
    else
    begin
      unique case (st_r)
        hbs_pkg::HBS_IDLE:
        begin
          if (!local_bus_mode && hit && (rd_lead || (wr_d_r && !wr_s)))
          begin
            st_r            <= hbs_pkg::HBS_WAIT;
            wcnt_r          <= 8'(WAIT_CNT);
            async_ready_out <= 1'b0; // RQ7
          end
          else if (local_bus_mode && hit && cyc_first)
            st_r <= hbs_pkg::HBS_LOCAL;
        end
        hbs_pkg::HBS_WAIT:
        begin
          if (wcnt_r <= 8'h01)
          begin
            st_r            <= hbs_pkg::HBS_DONE;
            async_ready_out <= 1'b1; // RQ7
          end
          else
            wcnt_r <= wcnt_r - 8'h01;
        end
        hbs_pkg::HBS_DONE:
        begin
          if (rd_s && wr_s)
            st_r <= hbs_pkg::HBS_IDLE;
        end
        hbs_pkg::HBS_LOCAL:
        begin
          if (cyc_s)
            st_r <= hbs_pkg::HBS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // User-side strobes and data
  // ==========================================================================
  logic rd_go, wr_go;
  assign rd_go = hit && lanes_legal(ebe) &&
                 (local_bus_mode ? (cyc_first && !wnr_s) : rd_lead); // RQ5
  assign wr_go = hit && lanes_legal(ebe) &&
                 (local_bus_mode ? (st_r == hbs_pkg::HBS_LOCAL && cyc_s && dir_r)
                                 : wr_trail); // RQ6
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_addr       <= '0;
      reg_lanes      <= hbs_pkg::LANES_NONE;
      reg_wr_pulse   <= 1'b0;
      reg_rd_pulse   <= 1'b0;
      reg_wr_data    <= '0;
      host_data_out  <= '0;
      host_data_oe_n <= '1;
    end
    else
    begin
      reg_rd_pulse <= rd_go;
      reg_wr_pulse <= wr_go;
      if (rd_go || wr_go)
      begin
        reg_addr  <= ea;
        reg_lanes <= ebe;
      end
      if (wr_go)
        reg_wr_data <= d_s; // RQ6
      host_data_out <= reg_rd_data;
      for (int i = 0; i < 4; i++)
      begin
        host_data_oe_n[i*8 +: 8] <= {8{!(hit && !ebe[i] && !rd_s && !local_bus_mode)
                                       && !(hit && !ebe[i] && local_bus_mode
                                            && !dir_r && st_r == hbs_pkg::HBS_LOCAL)}};
      end
    end
  end

  // ==========================================================================
  // Checks
  property p_claim;
    hit |=> !local_device_claim_n;
  endproperty
  a_claim: assert property (p_claim) else $error("claim not driven on hit"); // RQ8
  property p_noclaim;
    eaen |=> local_device_claim_n;
  endproperty
  a_noclaim: assert property (p_noclaim) else $error("claim with qualifier high"); // RQ3
  sequence s_rd_start;
    !local_bus_mode && hit && rd_lead && st_r == hbs_pkg::HBS_IDLE;
  endsequence
  property p_ready_drop;
    s_rd_start |=> !async_ready_out;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready not dropped"); // RQ7
  property p_ready_rise;
    $fell(async_ready_out) |-> ##[1:256] async_ready_out;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready stuck low"); // RQ7
  property p_wr_data;
    wr_go |=> reg_wr_pulse && reg_wr_data == $past(d_s);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not captured"); // RQ6
  property p_rd_pulse;
    reg_rd_pulse |-> $past(hit) && !$past(eaen);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read outside decode"); // RQ5
  property p_lanes;
    (reg_rd_pulse || reg_wr_pulse) |-> lanes_legal(reg_lanes);
  endproperty
  a_lanes: assert property (p_lanes) else $error("illegal lane pattern"); // RQ1
  property p_upper;
    (!local_bus_mode && reg_wr_pulse) |-> reg_lanes[3:2] == 2'b11;
  endproperty
  a_upper: assert property (p_upper) else $error("upper lanes used on io bus"); // RQ2
  property p_dir;
    cyc_first |=> dir_r == $past(wnr_s);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not sampled"); // RQ9
  property p_hold;
    (ads_s && $past(ads_s)) |-> la_r == $past(la_r);
  endproperty
  a_hold: assert property (p_hold) else $error("address not held"); // RQ10
  property p_decode;
    reg_wr_pulse |-> reg_addr[15:4] == io_base;
  endproperty
  a_decode: assert property (p_decode) else $error("write outside space"); // RQ4
endmodule

/* File: src/hbs_pkg.sv */
// Constants and types for the host bus slave port.
// Function
// (RQ1) Four active-low byte-lane enables pick doubleword, low word, high word or single byte.
// (RQ2) On the asynchronous I/O bus the port behaves as a 16-bit peripheral on the low two lanes.
// (RQ3) An access is accepted only while the I/O-space qualifier is low.
// (RQ4) Address lines 1 to 15 decode the I/O space and select the internal register.
// (RQ5) Reads run on an active-low read strobe with the address valid before its leading edge.
// (RQ6) Write data is captured at the trailing edge of the active-low write strobe.
// (RQ7) Ready drops at a strobe's leading edge when needed and rises at the first clock after; the code holds it low for WAIT_CNT clocks (2 by default).
// (RQ8) The local-device claim is driven push-pull low on a match of lines 15 to 4 with qualifier low.
// (RQ9) In local-bus mode the direction is sampled on the first clock with cycle-start active.
// (RQ10) In local-bus mode address and byte enables pass while the strobe is low and hold after.
package hbs_pkg;

  // ==========================================================================
  // Decode, lane and wait constants
  // ==========================================================================
  localparam logic [11:0] BASE_RESET      = 12'h030;
  localparam logic [3:0]  LANES_DWORD     = 4'h0;
  localparam logic [3:0]  LANES_LOW_WORD  = 4'hC;
  localparam logic [3:0]  LANES_HIGH_WORD = 4'h3;
  localparam logic [3:0]  LANES_NONE      = 4'hF;
  localparam int          WAIT_CYCLES     = 2;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [3:0]
  {
    HBS_IDLE  = 4'h1,
    HBS_WAIT  = 4'h2,
    HBS_DONE  = 4'h4,
    HBS_LOCAL = 4'h8
  } hbs_state_t;

endpackage

/* File: dv/hbs_host_model.sv */
// Host bus master model driving the asynchronous and local-bus pins.
module hbs_host_model
(
  // Clock and handshake
  input  wire logic        ref_clk,
  input  wire logic        async_ready_out,
  // Host pins
  output logic      [15:1] host_addr,
  output logic      [3:0]  byte_lane_enables_n,
  output logic             io_space_qualifier,
  output logic             address_strobe_n,
  output logic             cycle_start_n,
  output logic             write_not_read_dir,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic      [31:0] host_data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    host_addr = 15'h0000;
    byte_lane_enables_n = 4'hF;
    io_space_qualifier = 1'b1;
    address_strobe_n = 1'b1;
    cycle_start_n = 1'b1;
    write_not_read_dir = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_data_in = 32'h0000_0000;
  end

  // ==========================================================================
  // Asynchronous strobe cycle
  // ==========================================================================
  // Write data is wrong until mid-strobe, so an early capture shows up.
  task automatic io_cycle(input logic wr, input logic [15:1] a, input logic [3:0] be,
                          input logic q, input logic [31:0] d);
    @(negedge ref_clk);
    host_addr = a;
    byte_lane_enables_n = be;
    io_space_qualifier = q;
    host_data_in = ~d;
    @(negedge ref_clk);
    read_strobe_n = wr;
    write_strobe_n = ~wr;
    repeat (3) @(negedge ref_clk);
    host_data_in = d;
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 20 && async_ready_out !== 1'b1; i++)
      @(negedge ref_clk);
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    // The qualifier ends the access one cycle after the strobe, so the claim
    // is gone before the next access starts.
    @(negedge ref_clk);
    io_space_qualifier = 1'b1;
    repeat (4) @(negedge ref_clk);
    host_data_in = ~d;
  endtask

  // ==========================================================================
  // Local-bus cycle
  // ==========================================================================
  // Pins are scrambled once the strobe rises; only the held copy is valid.
  task automatic lb_cycle(input logic wr, input logic [15:1] a, input logic [3:0] be);
    @(negedge ref_clk);
    host_addr = a;
    byte_lane_enables_n = be;
    io_space_qualifier = 1'b0;
    address_strobe_n = 1'b0;
    write_not_read_dir = wr;
    @(negedge ref_clk);
    address_strobe_n = 1'b1;
    @(negedge ref_clk);
    host_addr = ~a;
    byte_lane_enables_n = ~be;
    io_space_qualifier = 1'b1;
    cycle_start_n = 1'b0;
    @(negedge ref_clk);
    cycle_start_n = 1'b1;
    write_not_read_dir = ~wr;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule

/* File: dv/hbs_host_bus_slave_port_test.sv */
// Self-checking testbench for the host bus slave port.
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module hbs_host_bus_slave_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        local_bus_mode = 1'b0;
  logic [11:0] io_base = 12'h000;
  logic [15:1] host_addr, reg_addr, cap_addr, a;
  logic [3:0]  be_n, reg_lanes, cap_lanes;
  logic        q, ads_n, cyc_n, dir, rd_n, wr_n, rdy, claim_n, wp, rp, claim_seen;
  logic [31:0] din, dout, oe_n, reg_wr_data, reg_rd_data, cap_wd, oe_seen, do_seen;
  int          err_count = 0;
  int          checks_done = 0;
  int          rd_cnt, wr_cnt, rdy_low, kind;
  logic [3:0]  lanes16 [3] = '{4'hC, 4'hE, 4'hD};
  // The last pattern is not a legal lane choice and must be refused.
  logic [3:0]  lanes32 [8] = '{4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7, 4'hA};

  function automatic logic [31:0] rd_word(input logic [15:1] x);
    return {1'b1, x, 1'b0, ~x};
  endfunction

  always #4 ref_clk = ~ref_clk;
  assign reg_rd_data = rd_word(reg_addr);

  hbs_host_bus_slave_port u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .local_bus_mode(local_bus_mode), .io_base(io_base), .host_addr(host_addr),
    .byte_lane_enables_n(be_n), .io_space_qualifier(q), .address_strobe_n(ads_n),
    .cycle_start_n(cyc_n), .write_not_read_dir(dir), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .host_data_in(din), .host_data_out(dout),
    .host_data_oe_n(oe_n), .async_ready_out(rdy), .local_device_claim_n(claim_n),
    .reg_addr(reg_addr), .reg_lanes(reg_lanes), .reg_wr_pulse(wp), .reg_rd_pulse(rp),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));

  hbs_host_model u_host (.ref_clk(ref_clk), .async_ready_out(rdy), .host_addr(host_addr),
    .byte_lane_enables_n(be_n), .io_space_qualifier(q), .address_strobe_n(ads_n),
    .cycle_start_n(cyc_n), .write_not_read_dir(dir), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .host_data_in(din));

  // ==========================================================================
  // Monitor
  // ==========================================================================
  // Outputs are read mid-cycle, where they have settled.
  always @(negedge ref_clk)
  begin
    if (rp === 1'b1 || wp === 1'b1)
    begin
      rd_cnt += (rp === 1'b1);
      wr_cnt += (wp === 1'b1);
      cap_addr = reg_addr;
      cap_lanes = reg_lanes;
      cap_wd = reg_wr_data;
    end
    rdy_low += (rdy === 1'b0);
    if (claim_n === 1'b0)
      claim_seen = 1'b1;
    if (oe_n !== 32'hFFFF_FFFF)
    begin
      oe_seen = oe_n;
      do_seen = dout;
    end
  end

  task automatic clear_marks();
    rd_cnt = 0;
    wr_cnt = 0;
    rdy_low = 0;
    claim_seen = 1'b0;
    oe_seen = 32'hFFFF_FFFF;
  endtask

  // ==========================================================================
  // Access checks
  // ==========================================================================
  task automatic run_io(input logic wr, input logic [15:1] a, input logic [3:0] be,
                        input logic qv, input logic [31:0] d, input logic ok);
    clear_marks();
    u_host.io_cycle(wr, a, be, qv, d);
    `CHK("rd pulses", int'(ok && !wr), rd_cnt)
    `CHK("wr pulses", int'(ok && wr), wr_cnt)
    `CHK("claim", ok, claim_seen)
    `CHK("ready low", ok ? hbs_pkg::WAIT_CYCLES : 0, rdy_low)
    if (ok)
    begin
      `CHK("addr", a, cap_addr)
      `CHK("lanes", {2'b11, be[1:0]}, cap_lanes)
      if (wr)
        `CHK("wdata", d[15:0], cap_wd[15:0])
      else
      begin
        `CHK("oe", {16'hFFFF, {8{be[1]}}, {8{be[0]}}}, oe_seen)
        `CHK("rdata", rd_word(a) & 32'h0000_FFFF, do_seen & 32'h0000_FFFF)
      end
    end
  endtask

  task automatic run_lb(input logic wr, input logic [15:1] a, input logic [3:0] be,
                        input logic ok);
    clear_marks();
    u_host.lb_cycle(wr, a, be);
    `CHK("lb rd", int'(ok && !wr), rd_cnt)
    `CHK("lb wr", int'(ok && wr), wr_cnt)
    `CHK("lb claim", 1'b1, claim_seen)
    if (ok)
    begin
      `CHK("lb addr", a, cap_addr)
      `CHK("lb lanes", be, cap_lanes)
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial
  begin
    void'($urandom(32'h8EDA));
    io_base = 12'($urandom);
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 24; i++)
    begin
      kind = $urandom % 4;
      a = {io_base, 3'($urandom)};
      if (kind == 1)
        a[15:4] = io_base ^ 12'($urandom_range(1, 4095));
      run_io(1'($urandom), a, lanes16[$urandom % 3] | {2'($urandom), 2'h0},
             kind == 0, $urandom, kind > 1);
    end
    local_bus_mode = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 8; i++)
      run_lb(1'($urandom), {io_base, 2'($urandom), 1'b0}, lanes32[i], i < 7);
    summarize();
  end

  // The whole run needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    summarize();
  end
endmodule
